// ### btc_pkg.sv
package btc_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_NS   = 40;            // 25 MHz clock period
   localparam int unsigned TICK_NS  = 1_000_000_000; // One second
   localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_THR  = 8'h04;
   localparam logic [7:0] REG_HYST = 8'h08;
   localparam logic [7:0] REG_CYC  = 8'h0C;
   localparam logic [7:0] REG_STAT = 8'h10;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SRC_LSB  = 4;
   localparam int CTRL_SOC_BIT  = 6;
   localparam int CTRL_OND_LSB  = 8;
   localparam int CTRL_OFFD_LSB = 12;
   localparam int STAT_OBJ_BIT  = 0;
   localparam int STAT_COND_BIT = 1;
   localparam int STAT_RUN_BIT  = 2;
   localparam int STAT_THR_LSB  = 16;

   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [15:0] CTRL_RST = 16'h0040; // Mode 0, no source, send on change
   localparam logic [15:0] THR_RST  = 16'h000A;
   localparam logic [15:0] HYST_RST = 16'h0000;
   localparam logic [15:0] CYC_RST  = 16'h0000;
   localparam logic [15:0] THR_MIN  = 16'h000A; // 10 lux
   localparam logic [15:0] THR_MAX  = 16'h028A; // 650 lux
   localparam logic [15:0] HYST_MAX = 16'h0258; // 600 lux

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_16 = 2'h1, SRC_8 = 2'h2, SRC_TEACH = 2'h3} btc_src_t;
   typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_ON = 2'h1, ACT_OFF = 2'h2} btc_act_t;

   typedef struct packed {
      logic     lower;  // Lower-threshold direction
      btc_act_t act_a;  // First crossing (beyond threshold)
      btc_act_t act_b;  // Return crossing (past hysteresis)
   } btc_mode_t;

   typedef struct packed {
      logic [3:0] off_dly;
      logic [3:0] on_dly;
      logic       soc;
      btc_src_t   src;
      logic [3:0] mode;
   } btc_cfg_t;

   typedef struct packed {
      logic valid;
      logic value;
   } btc_tx_t;

   // Action mode table; illegal codes behave as mode 0
   function automatic btc_mode_t mode_decode(input logic [3:0] m);
      unique case (m)
         4'h1:    mode_decode = '{1'b0, ACT_OFF, ACT_ON};
         4'h2:    mode_decode = '{1'b1, ACT_ON, ACT_OFF};
         4'h3:    mode_decode = '{1'b1, ACT_OFF, ACT_ON};
         4'h4:    mode_decode = '{1'b0, ACT_ON, ACT_NONE};
         4'h5:    mode_decode = '{1'b0, ACT_OFF, ACT_NONE};
         4'h6:    mode_decode = '{1'b1, ACT_ON, ACT_NONE};
         4'h7:    mode_decode = '{1'b1, ACT_OFF, ACT_NONE};
         4'h8:    mode_decode = '{1'b0, ACT_NONE, ACT_OFF};
         4'h9:    mode_decode = '{1'b0, ACT_NONE, ACT_ON};
         4'hA:    mode_decode = '{1'b1, ACT_NONE, ACT_OFF};
         4'hB:    mode_decode = '{1'b1, ACT_NONE, ACT_ON};
         default: mode_decode = '{1'b0, ACT_ON, ACT_OFF};
      endcase
   endfunction

   // Delay selector to seconds
   function automatic logic [11:0] dly_secs(input logic [3:0] s);
      unique case (s)
         4'h1:    dly_secs = 12'h001;
         4'h2:    dly_secs = 12'h003;
         4'h3:    dly_secs = 12'h005;
         4'h4:    dly_secs = 12'h00A;
         4'h5:    dly_secs = 12'h00F;
         4'h6:    dly_secs = 12'h01E;
         4'h7:    dly_secs = 12'h03C;
         4'h8:    dly_secs = 12'h0B4;
         4'h9:    dly_secs = 12'h12C;
         4'hA:    dly_secs = 12'h258;
         4'hB:    dly_secs = 12'h384;
         4'hC:    dly_secs = 12'h708;
         4'hD:    dly_secs = 12'hE10;
         default: dly_secs = 12'h000;
      endcase
   endfunction

   // Byte-lane merge of a write into a register image
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         be_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

endpackage

// ### btc_threshold_comparator.sv
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module btc_threshold_comparator
   import btc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        CE,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic [15:0] MEAS_VALUE,
   input  wire logic        EXT16_VALID,
   input  wire logic [15:0] EXT16_DATA,
   input  wire logic        EXT8_VALID,
   input  wire logic [7:0]  EXT8_DATA,
   input  wire logic        TEACH_STORE,
   output logic             TX_VALID,
   output logic             TX_VALUE
);

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
   end

   typedef enum logic [1:0] {DS_IDLE = 2'b01, DS_RUN = 2'b10} btc_dstate_t;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_s1_r;
   logic rst_n_r;

   // Async assert, sync release; not held by CE so reset always completes
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [15:0] ctrl_r,   ctrl_nxt;
   logic [15:0] cfg_thr_r, cfg_thr_nxt;
   logic [15:0] hyst_r,   hyst_nxt;
   logic [15:0] cyc_r,    cyc_nxt;
   logic [15:0] threshold_level_r, threshold_level_nxt;
   logic        wait_r,   wait_nxt;
   logic [31:0] rdata_r,  rdata_nxt;
   logic        cond_r,   cond_nxt;
   logic        obj_r,    obj_nxt;
   btc_dstate_t dst_r,    dst_nxt;
   logic [31:0] dpre_r,   dpre_nxt;
   logic [11:0] dsec_r,   dsec_nxt;
   logic [31:0] cpre_r,   cpre_nxt;
   logic [15:0] csec_r,   csec_nxt;
   btc_tx_t     tx_r,     tx_nxt;
   btc_cfg_t    cfg;
   btc_mode_t   md;
   logic        wr_en;
   logic [31:0] wmerge;
   logic [16:0] lo_pt;
   logic [16:0] hi_pt;
   btc_act_t    cur_act;
   logic        desired;
   logic [11:0] dsecs;
   logic        cyc_fire;
   logic        chg_send;

   assign cfg = btc_cfg_t'({ctrl_r[CTRL_OFFD_LSB +: 4], ctrl_r[CTRL_OND_LSB +: 4],
                            ctrl_r[CTRL_SOC_BIT], ctrl_r[CTRL_SRC_LSB +: 2],
                            ctrl_r[CTRL_MODE_LSB +: 4]});
   assign md  = mode_decode(cfg.mode);

   // ----------------------------------------
   // Register bus slave
   // ----------------------------------------
   // One wait state: request seen, then waitrequest low for one cycle
   assign wr_en = AVS_WRITE && !wait_r;

   always_comb begin
      wait_nxt  = 1'b1;
      rdata_nxt = rdata_r;
      if ((AVS_READ || AVS_WRITE) && wait_r) begin
         wait_nxt  = 1'b0;
         // Only reads load read data, so it holds across writes
         if (AVS_READ) begin
            rdata_nxt = 32'h0000_0000; // Unmapped reads return zero
            unique case (AVS_ADDRESS)
               REG_CTRL: rdata_nxt = {16'h0000, ctrl_r};
               REG_THR:  rdata_nxt = {16'h0000, cfg_thr_r};
               REG_HYST: rdata_nxt = {16'h0000, hyst_r};
               REG_CYC:  rdata_nxt = {16'h0000, cyc_r};
               REG_STAT: begin
                  rdata_nxt[STAT_OBJ_BIT]         = obj_r;
                  rdata_nxt[STAT_COND_BIT]        = cond_r;
                  rdata_nxt[STAT_RUN_BIT]         = (dst_r == DS_RUN);
                  rdata_nxt[STAT_THR_LSB +: 16]   = threshold_level_r;
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if (CE) begin
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Configuration and active threshold
   // ----------------------------------------
   always_comb begin
      ctrl_nxt            = ctrl_r;
      cfg_thr_nxt         = cfg_thr_r;
      hyst_nxt            = hyst_r;
      cyc_nxt             = cyc_r;
      threshold_level_nxt = threshold_level_r;
      wmerge              = 32'h0000_0000;
      unique case (cfg.src)
         SRC_16:    if (EXT16_VALID) threshold_level_nxt = EXT16_DATA;
         SRC_8:     if (EXT8_VALID) threshold_level_nxt = {8'h00, EXT8_DATA};
         SRC_TEACH: if (TEACH_STORE) threshold_level_nxt = MEAS_VALUE;
         default:   ;
      endcase
      if (wr_en) begin
         unique case (AVS_ADDRESS)
            REG_CTRL: begin
               wmerge   = be_merge({16'h0000, ctrl_r}, AVS_WRITEDATA, AVS_BYTEENABLE);
               ctrl_nxt = wmerge[15:0];
            end
            REG_THR: begin
               wmerge = be_merge({16'h0000, cfg_thr_r}, AVS_WRITEDATA, AVS_BYTEENABLE);
               // Clamp into the selectable range
               if (wmerge[15:0] < THR_MIN) cfg_thr_nxt = THR_MIN;
               else if (wmerge[15:0] > THR_MAX) cfg_thr_nxt = THR_MAX;
               else cfg_thr_nxt = wmerge[15:0];
               // Download wins over any external value this cycle
               threshold_level_nxt = cfg_thr_nxt;
            end
            REG_HYST: begin
               wmerge   = be_merge({16'h0000, hyst_r}, AVS_WRITEDATA, AVS_BYTEENABLE);
               hyst_nxt = (wmerge[15:0] > HYST_MAX) ? HYST_MAX : wmerge[15:0];
            end
            REG_CYC: begin
               wmerge  = be_merge({16'h0000, cyc_r}, AVS_WRITEDATA, AVS_BYTEENABLE);
               cyc_nxt = wmerge[15:0];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r            <= CTRL_RST;
         cfg_thr_r         <= THR_RST;
         hyst_r            <= HYST_RST;
         cyc_r             <= CYC_RST;
         threshold_level_r <= THR_RST;
      end else if (CE) begin
         ctrl_r            <= ctrl_nxt;
         cfg_thr_r         <= cfg_thr_nxt;
         hyst_r            <= hyst_nxt;
         cyc_r             <= cyc_nxt;
         threshold_level_r <= threshold_level_nxt;
      end
   end

   // ----------------------------------------
   // Comparator with hysteresis
   // ----------------------------------------
   // Return point saturates at zero rather than wrapping
   assign lo_pt = ({1'b0, threshold_level_r} > {1'b0, hyst_r}) ?
                  17'({1'b0, threshold_level_r} - {1'b0, hyst_r}) : 17'h0_0000;
   assign hi_pt = 17'({1'b0, threshold_level_r} + {1'b0, hyst_r});

   always_comb begin
      cond_nxt = cond_r;
      if (!md.lower) begin
         if (MEAS_VALUE > threshold_level_r) cond_nxt = 1'b1;
         else if ({1'b0, MEAS_VALUE} < lo_pt) cond_nxt = 1'b0;
      end else begin
         if (MEAS_VALUE < threshold_level_r) cond_nxt = 1'b1;
         else if ({1'b0, MEAS_VALUE} > hi_pt) cond_nxt = 1'b0;
      end
   end

   // Action of whichever crossing condition currently holds
   assign cur_act = cond_r ? md.act_a : md.act_b;
   // No-telegram action leaves the object where it is
   assign desired = (cur_act == ACT_ON) ? 1'b1 :
                    (cur_act == ACT_OFF) ? 1'b0 : obj_r;
   assign dsecs   = desired ? dly_secs(cfg.on_dly) : dly_secs(cfg.off_dly);

   // ----------------------------------------
   // Switch delay and object value
   // ----------------------------------------
   // One timer serves both delays: only one change can be pending
   always_comb begin
      dst_nxt  = dst_r;
      dpre_nxt = dpre_r;
      dsec_nxt = dsec_r;
      obj_nxt  = obj_r;
      chg_send = 1'b0;
      if (desired == obj_r) begin
         dst_nxt = DS_IDLE;
      end else begin
         unique case (dst_r)
            DS_IDLE: begin
               if (dsecs == 12'h000) begin
                  obj_nxt  = desired;
                  chg_send = cfg.soc;
               end else begin
                  dst_nxt  = DS_RUN;
                  dpre_nxt = 32'h0000_0000;
                  dsec_nxt = dsecs;
               end
            end
            DS_RUN: begin
               if (dsec_r == 12'h000) begin
                  // Object changes only now, so cyclic sends carried the old value
                  obj_nxt  = desired;
                  chg_send = cfg.soc;
                  dst_nxt  = DS_IDLE;
               end else if (dpre_r == 32'(TICK_CYCLES - 1)) begin
                  dpre_nxt = 32'h0000_0000;
                  dsec_nxt = 12'(dsec_r - 12'h001);
               end else begin
                  dpre_nxt = 32'(dpre_r + 32'h0000_0001);
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cond_r <= 1'b0;
         obj_r  <= 1'b0;
         dst_r  <= DS_IDLE;
         dpre_r <= 32'h0000_0000;
         dsec_r <= 12'h000;
      end else if (CE) begin
         cond_r <= cond_nxt;
         obj_r  <= obj_nxt;
         dst_r  <= dst_nxt;
         dpre_r <= dpre_nxt;
         dsec_r <= dsec_nxt;
      end
   end

   // ----------------------------------------
   // Cyclic timer and transmit
   // ----------------------------------------
   always_comb begin
      cpre_nxt = cpre_r;
      csec_nxt = csec_r;
      cyc_fire = 1'b0;
      if (cyc_r == 16'h0000) begin
         cpre_nxt = 32'h0000_0000;
         csec_nxt = 16'h0000;
      end else if (cpre_r == 32'(TICK_CYCLES - 1)) begin
         cpre_nxt = 32'h0000_0000;
         if (csec_r >= 16'(cyc_r - 16'h0001)) begin
            csec_nxt = 16'h0000;
            cyc_fire = 1'b1;
         end else begin
            csec_nxt = 16'(csec_r + 16'h0001);
         end
      end else begin
         cpre_nxt = 32'(cpre_r + 32'h0000_0001);
      end
   end

   // Change and cyclic send in one cycle give a single telegram
   always_comb begin
      tx_nxt.valid = chg_send || (cyc_fire && (cur_act != ACT_NONE));
      tx_nxt.value = chg_send ? obj_nxt : obj_r;
   end

   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cpre_r <= 32'h0000_0000;
         csec_r <= 16'h0000;
         tx_r   <= '0;
      end else if (CE) begin
         cpre_r <= cpre_nxt;
         csec_r <= csec_nxt;
         tx_r   <= tx_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign AVS_READDATA    = rdata_r;
   assign AVS_WAITREQUEST = wait_r;
   assign TX_VALID        = tx_r.valid;
   assign TX_VALUE        = tx_r.value;

endmodule

// ### btc_asserts.sv
`timescale 1ns/10ps
module btc_asserts
   import btc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic        CE,
   input wire logic [7:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        TX_VALID,
   input wire logic        TX_VALUE
);
   // ----------------------------------------
   // Shadow of the send controls
   // ----------------------------------------
   logic        soc_r, soc_nxt, last_r, last_nxt, clean_r, clean_nxt, wr;
   logic [15:0] cyc_r, cyc_nxt;
   assign wr = AVS_WRITE && !AVS_WAITREQUEST;
   // Next values from acknowledged writes and telegrams
   always_comb begin
      soc_nxt = soc_r;
      cyc_nxt = cyc_r;
      last_nxt = TX_VALID ? TX_VALUE : last_r;
      clean_nxt = clean_r && soc_r;  // An unsent change breaks alternation
      if (wr && AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0]) soc_nxt = AVS_WRITEDATA[CTRL_SOC_BIT];
      if (wr && AVS_ADDRESS == REG_CYC && AVS_BYTEENABLE[0]) cyc_nxt[7:0] = AVS_WRITEDATA[7:0];
      if (wr && AVS_ADDRESS == REG_CYC && AVS_BYTEENABLE[1]) cyc_nxt[15:8] = AVS_WRITEDATA[15:8];
   end
   // Registers
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         soc_r <= CTRL_RST[CTRL_SOC_BIT];
         cyc_r <= CYC_RST;
         last_r <= 1'b0;
         clean_r <= 1'b1;
      end else begin
         soc_r <= soc_nxt;
         cyc_r <= cyc_nxt;
         last_r <= last_nxt;
         clean_r <= clean_nxt;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   property p_ack_next;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE |=> !AVS_WAITREQUEST;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered after one wait");
   property p_ack_one;
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("acknowledge longer than one cycle");
   property p_no_spont;
      !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST;
   endproperty
   a_no_spont: assert property (p_no_spont) else $error("acknowledge without request");
   property p_rd_hold;
      !(AVS_READ && !AVS_WAITREQUEST) |-> $stable(AVS_READDATA);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed outside a read");
   property p_rd_unmapped;
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > REG_STAT |-> AVS_READDATA == 32'h0000_0000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
   property p_freeze;
      !CE |=> $stable(TX_VALUE) && $stable(AVS_WAITREQUEST);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
   property p_quiet;
      !soc_r && cyc_r == 16'h0000 && $past(!soc_r && cyc_r == 16'h0000) |-> !TX_VALID;
   endproperty
   a_quiet: assert property (p_quiet) else $error("telegram with all sending off");
   property p_alt;
      clean_r && cyc_r == 16'h0000 && $past(cyc_r) == 16'h0000 && TX_VALID |-> TX_VALUE != last_r;
   endproperty
   a_alt: assert property (p_alt) else $error("change telegram repeats old value");
   c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
   c_on: cover property (TX_VALID && TX_VALUE);
   c_off: cover property (TX_VALID && !TX_VALUE);
endmodule
bind btc_threshold_comparator btc_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .CLK(CLK), .NRST(NRST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_VALID(TX_VALID),
   .TX_VALUE(TX_VALUE));

// ### btc_bus_peer.sv
`timescale 1ns/10ps
module btc_bus_peer (
   input  wire logic        clk,
   output logic             ext16_valid,
   output logic [15:0]      ext16_data,
   output logic             ext8_valid,
   output logic [7:0]       ext8_data,
   output logic             teach_store
);
   // Quiet at time zero; data lines carry noise until a value is sent
   initial begin
      ext16_valid = 1'b0;
      ext8_valid = 1'b0;
      teach_store = 1'b0;
      ext16_data = 16'hA5A5;
      ext8_data = 8'h5A;
   end
   // Released lines are inverted so a stale value never looks valid
   task automatic send16(input logic [15:0] v);
      @(posedge clk);
      ext16_valid <= 1'b1;
      ext16_data <= v;
      @(posedge clk);
      ext16_valid <= 1'b0;
      ext16_data <= ~v;
   endtask
   task automatic send8(input logic [7:0] v);
      @(posedge clk);
      ext8_valid <= 1'b1;
      ext8_data <= v;
      @(posedge clk);
      ext8_valid <= 1'b0;
      ext8_data <= ~v;
   endtask
   task automatic teach;
      @(posedge clk);
      teach_store <= 1'b1;
      @(posedge clk);
      teach_store <= 1'b0;
   endtask
endmodule

// ### btc_threshold_comparator_tb.sv
`timescale 1ns/10ps
module btc_threshold_comparator_tb;
   import btc_pkg::*;
   localparam int unsigned TK = 4;
   localparam logic [23:0] ACT_A = 24'h009999;  // Per mode: 1 on, 2 off, 0 none
   localparam logic [23:0] ACT_B = 24'h660066;
   logic        CLK, NRST, CE, RD, WR, WAITQ, E16V, E8V, TCH, TXV, TXB, obj;
   logic [7:0]  ADR, E8D;
   logic [15:0] MEAS, E16D;
   logic [31:0] WD, RDAT, q;
   int          n_errors, check_count, c;
   btc_threshold_comparator #(.TICK_CYCLES(TK)) uut (.CLK(CLK), .NRST(NRST), .CE(CE),
      .AVS_ADDRESS(ADR), .AVS_READ(RD), .AVS_WRITE(WR), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(WD),
      .AVS_READDATA(RDAT), .AVS_WAITREQUEST(WAITQ), .MEAS_VALUE(MEAS), .EXT16_VALID(E16V),
      .EXT16_DATA(E16D), .EXT8_VALID(E8V), .EXT8_DATA(E8D), .TEACH_STORE(TCH), .TX_VALID(TXV),
      .TX_VALUE(TXB));
   btc_bus_peer peer (.clk(CLK), .ext16_valid(E16V), .ext16_data(E16D), .ext8_valid(E8V),
      .ext8_data(E8D), .teach_store(TCH));
   // 25 MHz clock
   always #20 CLK = ~CLK;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge CLK);
      RD <= !w;
      WR <= w;
      ADR <= a;
      WD <= d;
      i = 0;
      do begin
         @(posedge CLK);
         i++;
      end while (WAITQ !== 1'b0 && i < 20);
      q = RDAT;
      RD <= 1'b0;
      WR <= 1'b0;
      if (i >= 20) begin
         n_errors++;
         finish_test();
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   // Active threshold half of the status word
   task automatic rdt(input string nm, input logic [15:0] e);
      bus(1'b0, REG_STAT, 32'h0);
      chk(nm, {16'h0, e}, {16'h0, q[31:16]});
   endtask
   task automatic cfg(input logic [3:0] m, input logic [1:0] s, input logic soc, input logic [7:0] dl);
      bus(1'b1, REG_CTRL, {16'h0, dl, 1'b0, soc, s, m});
   endtask
   task automatic setm(input logic [15:0] v);
      @(posedge CLK);
      MEAS <= v;
   endtask
   // Count telegrams over n cycles, each must carry v
   task automatic txw(input logic v, input int n, input logic stop);
      c = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge CLK);
         if (TXV === 1'b1) begin
            c++;
            chk("telegram value", {31'h0, v}, {31'h0, TXB});
            if (stop) break;
         end
      end
   endtask
   task automatic do_reset;
      NRST <= 1'b0;
      repeat (10) @(posedge CLK);
      NRST <= 1'b1;
      repeat (3) @(posedge CLK);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      rdc("ctrl", REG_CTRL, 32'h0000_0040);
      rdc("stat", REG_STAT, 32'h000A_0000);
      bus(1'b1, 8'h14, 32'h0000_1234);
      rdc("unmapped", 8'h14, 32'h0);
      bus(1'b1, REG_THR, 32'h0000_0005);
      rdc("thr low", REG_THR, 32'h0000_000A);
      bus(1'b1, REG_THR, 32'h0000_02BC);
      rdc("thr high", REG_THR, 32'h0000_028A);
      bus(1'b1, REG_HYST, 32'h0000_02BC);
      rdc("hyst high", REG_HYST, 32'h0000_0258);
      $display("test regs done");
   endtask
   task automatic t_hyst;
      cfg(4'h0, 2'h0, 1'b1, 8'h00);
      bus(1'b1, REG_THR, 32'h0000_0064);
      bus(1'b1, REG_HYST, 32'h0000_0014);
      setm(16'h0032);
      txw(1'b0, 10, 1'b0);
      setm(16'h0064);
      txw(1'b1, 10, 1'b0);
      chk("at threshold", 32'h0, c);
      setm(16'h0065);
      txw(1'b1, 10, 1'b1);
      chk("above", 32'h1, c);
      setm(16'h0050);
      txw(1'b0, 10, 1'b0);
      chk("inside band", 32'h0, c);
      setm(16'h004F);
      txw(1'b0, 10, 1'b1);
      chk("below band", 32'h1, c);
      $display("test hyst done");
   endtask
   // Every mode: cross beyond threshold, then back past the band
   task automatic t_modes;
      logic [1:0] act;
      obj = 1'b0;
      for (int m = 0; m < 12; m++) begin
         setm(16'h0064);
         cfg(m[3:0], 2'h0, 1'b1, 8'h00);
         // Step 0 catches the return action applied by the new mode itself
         for (int s = 0; s < 3; s++) begin
            act = (s == 1) ? ACT_A[2*m +: 2] : ACT_B[2*m +: 2];
            setm((s == 0) ? 16'h0064 : (m[1] ^ (s == 2)) ? 16'h004F : 16'h0079);
            txw(act == 2'h1, 10, 1'b1);
            chk("mode telegram", {31'h0, act != 2'h0 && (act == 2'h1) != obj}, c);
            if (c != 0) obj = (act == 2'h1);
         end
      end
      $display("test modes done");
   endtask
   task automatic t_src;
      setm(16'h0064);
      cfg(4'h0, 2'h0, 1'b1, 8'h00);
      peer.send16(16'h012C);
      rdt("no source", 16'h0064);
      cfg(4'h0, 2'h1, 1'b1, 8'h00);
      peer.send16(16'h012C);
      peer.send8(8'h37);
      rdt("ext16", 16'h012C);
      cfg(4'h0, 2'h2, 1'b1, 8'h00);
      peer.send8(8'h37);
      rdt("ext8", 16'h0037);
      cfg(4'h0, 2'h3, 1'b1, 8'h00);
      setm(16'h00DE);
      peer.teach();
      rdt("teach", 16'h00DE);
      bus(1'b1, REG_THR, 32'h0000_0096);
      rdt("download", 16'h0096);
      $display("test sources done");
   endtask
   // On delay 1 s, off delay 3 s at TK cycles a second
   task automatic t_delay;
      cfg(4'h0, 2'h0, 1'b1, 8'h21);
      bus(1'b1, REG_THR, 32'h0000_0064);
      bus(1'b1, REG_HYST, 32'h0);
      setm(16'h0032);
      repeat (40) @(posedge CLK);
      setm(16'h0065);
      txw(1'b1, TK, 1'b0);
      chk("on delay early", 32'h0, c);
      txw(1'b1, 8, 1'b1);
      chk("on delay end", 32'h1, c);
      setm(16'h0063);
      txw(1'b0, 3 * TK, 1'b0);
      chk("off delay early", 32'h0, c);
      txw(1'b0, 8, 1'b1);
      chk("off delay end", 32'h1, c);
      setm(16'h0065);
      setm(16'h0032);
      txw(1'b0, 20, 1'b0);
      chk("reverted", 32'h0, c);
      $display("test delay done");
   endtask
   task automatic t_cyc;
      cfg(4'h0, 2'h0, 1'b1, 8'h33);
      bus(1'b1, REG_CYC, 32'h1);
      setm(16'h0065);
      txw(1'b0, 16, 1'b0);
      chk("cyclic during on delay", 32'h1, c > 1);
      repeat (20) @(posedge CLK);
      setm(16'h0032);
      txw(1'b1, 16, 1'b0);
      chk("cyclic during off delay", 32'h1, c > 1);
      cfg(4'h4, 2'h0, 1'b1, 8'h00);
      repeat (30) @(posedge CLK);
      txw(1'b0, 20, 1'b0);
      chk("no-telegram cyclic", 32'h0, c);
      setm(16'h0065);
      txw(1'b1, 20, 1'b0);
      chk("cyclic on", 32'h1, c > 2);
      bus(1'b1, REG_CYC, 32'h0);
      $display("test cyclic done");
   endtask
   task automatic t_quiet;
      cfg(4'h0, 2'h0, 1'b0, 8'h00);
      setm(16'h0032);
      CE <= 1'b0;
      repeat (5) @(posedge CLK);
      CE <= 1'b1;
      txw(1'b0, 10, 1'b0);
      setm(16'h0065);
      txw(1'b0, 10, 1'b0);
      chk("silent", 32'h0, c);
      do_reset();
      rdc("ctrl after reset", REG_CTRL, 32'h0000_0040);
      $display("test quiet done");
   endtask
   initial begin
      {CLK, CE, RD, WR, ADR, WD, MEAS, n_errors, check_count} = '0;
      NRST = 1'b0;
      CE = 1'b1;
      do_reset();
      t_regs();
      t_hyst();
      t_modes();
      t_src();
      t_delay();
      t_cyc();
      t_quiet();
      finish_test();
   end
endmodule
